// File: rtl/pac_pkg.sv
// register map, alarm type codes and reset values of the alarm comparator
// assumes a 32-bit axi4-lite register bus and 16-bit signed fixed-point process data
package pac_pkg;
    localparam int          PAC_NCH       = 4;
    localparam int          PAC_VW        = 16;
    // byte offsets, per-channel registers stride by one word
    localparam logic [7:0]  OFF_ASSIGN    = 8'h00;
    localparam logic [7:0]  OFF_STATUS    = 8'h04;
    localparam logic [7:0]  OFF_TYPE      = 8'h10;
    localparam logic [7:0]  OFF_VALUE     = 8'h20;
    localparam logic [7:0]  OFF_LIMIT     = 8'h30;
    localparam logic [7:0]  OFF_HYST      = 8'h40;
    // field positions
    localparam int          LIM_LO_POS    = 0;
    localparam int          LIM_HI_POS    = 16;
    localparam int          HYS_STD_POS   = 0;
    localparam int          HYS_MV_POS    = 16;
    // alarm type codes
    localparam logic [4:0]  T_NONE        = 5'h00;
    localparam logic [4:0]  T_UPLO        = 5'h01;
    localparam logic [4:0]  T_UP          = 5'h02;
    localparam logic [4:0]  T_LO          = 5'h03;
    localparam logic [4:0]  T_RANGE       = 5'h04;
    localparam logic [4:0]  T_UPLO_SB     = 5'h05;
    localparam logic [4:0]  T_UP_SB       = 5'h06;
    localparam logic [4:0]  T_LO_SB       = 5'h07;
    localparam logic [4:0]  T_ABS_UP      = 5'h08;
    localparam logic [4:0]  T_ABS_LO      = 5'h09;
    localparam logic [4:0]  T_ABS_UP_SB   = 5'h0a;
    localparam logic [4:0]  T_ABS_LO_SB   = 5'h0b;
    localparam logic [4:0]  T_LOOP        = 5'h0c;
    localparam logic [4:0]  T_RATE        = 5'h0d;
    localparam logic [4:0]  T_SP_UP       = 5'h0e;
    localparam logic [4:0]  T_SP_LO       = 5'h0f;
    localparam logic [4:0]  T_MV_UP       = 5'h10;
    localparam logic [4:0]  T_MV_LO       = 5'h11;
    localparam logic [4:0]  T_RSP_UP      = 5'h12;
    localparam logic [4:0]  T_RSP_LO      = 5'h13;
    // reset values; hysteresis in raw counts of 0.1 deg, 0.01 %FS or 0.01 %
    localparam logic [4:0]  TYPE_RST      = T_UP;
    localparam logic [15:0] HYS_STD_RST   = 16'h0002;
    localparam logic [15:0] HYS_MV_RST    = 16'h0032;
    localparam logic [15:0] HYS_MIN       = 16'h0001;
    localparam logic [15:0] HYS_MAX       = 16'h270f;
    localparam logic [3:0]  ASSIGN_RST    = 4'hf;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

// File: rtl/pac_alarm.sv
// four-channel process alarm comparator with axi4-lite register access
// assumes process data ports are synchronous to aclk and held steady between updates
module pac_alarm
    import pac_pkg::*;
#(
    parameter int NCH = PAC_NCH
) (
    // clock and reset
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    // axi4-lite slave
    input  wire logic [7:0]               s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [7:0]               s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    // process data, signed fixed point
    input  wire logic signed [PAC_VW-1:0] process_value,
    input  wire logic signed [PAC_VW-1:0] target_setpoint,
    input  wire logic signed [PAC_VW-1:0] remote_setpoint,
    input  wire logic signed [PAC_VW-1:0] manipulated_variable,
    input  wire logic signed [PAC_VW-1:0] cooling_manipulated_variable,
    // unit options
    input  wire logic                     heat_cool_mode,
    input  wire logic                     remote_setpoint_present,
    input  wire logic                     heater_detect_present,
    // alarm outputs
    output logic [NCH-1:0]                alarm_out
);

    generate
        if (NCH < 1 || NCH > PAC_NCH) begin : g_bad_nch
            $error("pac_alarm: NCH must lie between 1 and 4");
        end
    endgenerate
    typedef logic signed [17:0] pac_wide_t;
    // hysteresis state step for a rising alarm: on above thr, off at or below thr - hys
    function automatic logic pac_hi_step(logic st, pac_wide_t q, pac_wide_t thr, pac_wide_t hys);
        return (q > thr) ? 1'b1 : ((q <= thr - hys) ? 1'b0 : st);
    endfunction
    // hysteresis state step for a falling alarm: on below thr, off at or above thr + hys
    function automatic logic pac_lo_step(logic st, pac_wide_t q, pac_wide_t thr, pac_wide_t hys);
        return (q < thr) ? 1'b1 : ((q >= thr + hys) ? 1'b0 : st);
    endfunction
    function automatic pac_wide_t pac_wide(logic [15:0] v);
        return pac_wide_t'(signed'(v));
    endfunction
    function automatic logic pac_is_mv(logic [4:0] t);
        return (t == T_MV_UP) || (t == T_MV_LO);
    endfunction
    // clamp a written hysteresis into its legal span
    function automatic logic [15:0] pac_clamp(logic [15:0] v);
        return (v < HYS_MIN) ? HYS_MIN : ((v > HYS_MAX) ? HYS_MAX : v);
    endfunction

    // configuration registers
    logic [4:0]      type_r  [NCH];
    logic [15:0]     value_r [NCH];
    logic [31:0]     limit_r [NCH];
    logic [31:0]     hyst_r  [NCH];
    logic [NCH-1:0]  assign_r;
    logic            init_r;
    logic [NCH-1:0]  hi_r, lo_r;
    logic [NCH-1:0]  hi_nxt, lo_nxt;
    logic [NCH-1:0]  alarm_nxt;

    // write channel state
    logic [7:0]      awaddr_r;
    logic            aw_held_r;
    logic [31:0]     wdata_r;
    logic [3:0]      wstrb_r;
    logic            w_held_r;
    logic            wr_go;
    logic [7:0]      wr_off, rd_off;
    logic [1:0]      wr_idx, rd_idx;
    logic            wr_hit;

    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
    assign wr_go         = aw_held_r && w_held_r && !s_axi_bvalid;
    assign wr_off        = {awaddr_r[7:4], 4'h0};
    assign wr_idx        = awaddr_r[3:2];
    assign rd_off        = {s_axi_araddr[7:4], 4'h0};
    assign rd_idx        = s_axi_araddr[3:2];
    assign s_axi_arready = !s_axi_rvalid;

    // address and data are latched separately so either may arrive first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awaddr_r  <= 8'h00;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // decode of the held write address
    always_comb begin
        wr_hit = 1'b0;
        if (awaddr_r[1:0] == 2'h0) begin
            if (awaddr_r == OFF_ASSIGN || awaddr_r == OFF_STATUS)
                wr_hit = 1'b1;
            else if ((wr_off == OFF_TYPE || wr_off == OFF_VALUE || wr_off == OFF_LIMIT || wr_off == OFF_HYST)
                     && 32'(wr_idx) < NCH)
                wr_hit = 1'b1;
        end
    end

    // write response, one outstanding at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // channel assignment; heater-detect units leave channel 1 free until software claims it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            assign_r <= NCH'(ASSIGN_RST);
            init_r   <= 1'b1;
        end else if (init_r) begin
            init_r      <= 1'b0;
            assign_r[0] <= !heater_detect_present;
        end else if (wr_go && awaddr_r == OFF_ASSIGN && wstrb_r[0]) begin
            assign_r <= wdata_r[NCH-1:0];
        end
    end

    // per-channel configuration; a refused write still answers okay and keeps the old value
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NCH; i++) begin
                type_r[i]  <= TYPE_RST;
                value_r[i] <= 16'h0000;
                limit_r[i] <= 32'h0000_0000;
                hyst_r[i]  <= {HYS_MV_RST, HYS_STD_RST};
            end
        end else if (wr_go && wr_hit) begin
            for (int i = 0; i < NCH; i++) begin
                if (32'(wr_idx) == i) begin
                    if (wr_off == OFF_TYPE && wstrb_r[0] && wdata_r[4:0] <= T_RSP_LO) begin
                        // remote setpoint types need the remote input fitted
                        if (!(wdata_r[4:0] == T_RSP_UP || wdata_r[4:0] == T_RSP_LO) || remote_setpoint_present)
                            type_r[i] <= wdata_r[4:0];
                    end
                    if (wr_off == OFF_VALUE && wstrb_r[1:0] == 2'h3)
                        value_r[i] <= wdata_r[15:0];
                    if (wr_off == OFF_LIMIT) begin
                        if (wstrb_r[1:0] == 2'h3)
                            limit_r[i][LIM_LO_POS+:16] <= wdata_r[LIM_LO_POS+:16];
                        if (wstrb_r[3:2] == 2'h3)
                            limit_r[i][LIM_HI_POS+:16] <= wdata_r[LIM_HI_POS+:16];
                    end
                    if (wr_off == OFF_HYST && assign_r[i]
                        && type_r[i] != T_NONE && type_r[i] != T_LOOP && type_r[i] != T_RATE) begin
                        if (wstrb_r[1:0] == 2'h3)
                            hyst_r[i][HYS_STD_POS+:16] <= pac_clamp(wdata_r[HYS_STD_POS+:16]);
                        if (wstrb_r[3:2] == 2'h3)
                            hyst_r[i][HYS_MV_POS+:16] <= pac_clamp(wdata_r[HYS_MV_POS+:16]);
                    end
                end
            end
        end
    end

    // comparison of each channel; loop burnout and rate types are not evaluated here
    always_comb begin
        pac_wide_t pv, sp, x, h, l, hy;
        pv = pac_wide(process_value);
        sp = pac_wide(target_setpoint);
        x  = '0;
        h  = '0;
        l  = '0;
        hy = '0;
        hi_nxt    = '0;
        lo_nxt    = '0;
        alarm_nxt = '0;
        for (int i = 0; i < NCH; i++) begin
            x  = pac_wide(value_r[i]);
            h  = pac_wide(limit_r[i][LIM_HI_POS+:16]);
            l  = pac_wide(limit_r[i][LIM_LO_POS+:16]);
            hy = pac_is_mv(type_r[i]) ? pac_wide(hyst_r[i][HYS_MV_POS+:16])
                                      : pac_wide(hyst_r[i][HYS_STD_POS+:16]);
            unique case (type_r[i])
                T_UPLO, T_RANGE, T_UPLO_SB: begin
                    hi_nxt[i]    = pac_hi_step(hi_r[i], pv, sp + h, hy);
                    lo_nxt[i]    = pac_lo_step(lo_r[i], pv, sp - l, hy);
                    alarm_nxt[i] = (type_r[i] == T_RANGE) ? !(hi_nxt[i] || lo_nxt[i]) : (hi_nxt[i] || lo_nxt[i]);
                    // overlapping bands would chatter between limits, so hold the alarm off
                    if (type_r[i] == T_UPLO_SB && (h + l) <= (hy + hy))
                        alarm_nxt[i] = 1'b0;
                end
                T_UP, T_UP_SB: begin
                    hi_nxt[i]    = pac_hi_step(hi_r[i], pv, sp + x, hy);
                    alarm_nxt[i] = hi_nxt[i];
                end
                T_LO, T_LO_SB: begin
                    lo_nxt[i]    = pac_lo_step(lo_r[i], pv, sp - x, hy);
                    alarm_nxt[i] = lo_nxt[i];
                end
                T_ABS_UP, T_ABS_UP_SB: begin
                    hi_nxt[i]    = pac_hi_step(hi_r[i], pv, x, hy);
                    alarm_nxt[i] = hi_nxt[i];
                end
                T_ABS_LO, T_ABS_LO_SB: begin
                    lo_nxt[i]    = pac_lo_step(lo_r[i], pv, x, hy);
                    alarm_nxt[i] = lo_nxt[i];
                end
                T_SP_UP: begin
                    hi_nxt[i]    = pac_hi_step(hi_r[i], sp, x, hy);
                    alarm_nxt[i] = hi_nxt[i];
                end
                T_SP_LO: begin
                    lo_nxt[i]    = pac_lo_step(lo_r[i], sp, x, hy);
                    alarm_nxt[i] = lo_nxt[i];
                end
                T_MV_UP: begin
                    // manipulated_variable carries the heating output under heat/cool
                    hi_nxt[i]    = pac_hi_step(hi_r[i], pac_wide(manipulated_variable), x, hy);
                    alarm_nxt[i] = hi_nxt[i];
                end
                T_MV_LO: begin
                    lo_nxt[i]    = pac_lo_step(lo_r[i], heat_cool_mode ? pac_wide(cooling_manipulated_variable)
                                                                       : pac_wide(manipulated_variable), x, hy);
                    alarm_nxt[i] = lo_nxt[i];
                end
                T_RSP_UP: begin
                    // evaluated regardless of local or remote setpoint mode
                    hi_nxt[i]    = pac_hi_step(hi_r[i], pac_wide(remote_setpoint), x, hy);
                    alarm_nxt[i] = hi_nxt[i];
                end
                T_RSP_LO: begin
                    lo_nxt[i]    = pac_lo_step(lo_r[i], pac_wide(remote_setpoint), x, hy);
                    alarm_nxt[i] = lo_nxt[i];
                end
                default: alarm_nxt[i] = 1'b0;
            endcase
            // an unassigned channel is not usable and keeps no state
            if (!assign_r[i]) begin
                hi_nxt[i]    = 1'b0;
                lo_nxt[i]    = 1'b0;
                alarm_nxt[i] = 1'b0;
            end
        end
    end

    // alarm state and outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hi_r      <= '0;
            lo_r      <= '0;
            alarm_out <= '0;
        end else begin
            hi_r      <= hi_nxt;
            lo_r      <= lo_nxt;
            alarm_out <= alarm_nxt;
        end
    end

    // read channel; data is registered so rvalid comes one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_SLVERR;
            if (s_axi_araddr == OFF_ASSIGN) begin
                s_axi_rdata[NCH-1:0] <= assign_r;
                s_axi_rresp          <= RESP_OKAY;
            end else if (s_axi_araddr == OFF_STATUS) begin
                s_axi_rdata[NCH-1:0] <= alarm_out;
                s_axi_rresp          <= RESP_OKAY;
            end else if (s_axi_araddr[1:0] == 2'h0 && 32'(rd_idx) < NCH) begin
                s_axi_rresp <= RESP_OKAY;
                if (rd_off == OFF_TYPE)
                    s_axi_rdata[4:0] <= type_r[rd_idx];
                else if (rd_off == OFF_VALUE)
                    s_axi_rdata[15:0] <= value_r[rd_idx];
                else if (rd_off == OFF_LIMIT)
                    s_axi_rdata <= limit_r[rd_idx];
                else if (rd_off == OFF_HYST)
                    s_axi_rdata <= hyst_r[rd_idx];
                else
                    s_axi_rresp <= RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// File: dv/pac_alarm_chk.sv
// bus-side assertions of the alarm comparator, bound onto pac_alarm
// assumes a single clock domain, aresetn synchronous and active low
module pac_alarm_chk
    import pac_pkg::*;
(
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // axi4-lite handshakes seen at the slave
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // responses must stand until the master takes them
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rresp, s_axi_rdata}))
        else $error("read response changed before taken");
    a_bresp_clears: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released");
    // one transfer outstanding per direction
    a_read_blocks: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while response pending");
    a_write_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    // answer latency as handed over
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    // error reads carry no stale data
    a_error_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read returned data");
    a_bresp_legal: assert property (s_axi_bvalid |-> s_axi_bresp == RESP_OKAY || s_axi_bresp == RESP_SLVERR)
        else $error("illegal write response code");
endmodule
bind pac_alarm pac_alarm_chk i_pac_alarm_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// File: dv/test_pac_alarm.sv
// self-checking bench of the alarm comparator; every result is read back over axi4-lite
// assumes the hand-over register map and one-edge alarm latency
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin errors++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module test_pac_alarm
    import pac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0, aresetn, awvalid, wvalid, bready, arvalid, rready, hc, rsp_on, hd;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, alarm;
    logic [1:0] bresp, rresp;
    logic signed [15:0] pv, sp, rsp, mv, cmv;
    logic [33:0] q_r[$];
    logic [1:0] q_b[$];
    int errors = 0, checks = 0, cyc = 0;
    always #5 aclk = ~aclk;
    pac_alarm i_pac_alarm (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .process_value(pv), .target_setpoint(sp),
        .remote_setpoint(rsp), .manipulated_variable(mv), .cooling_manipulated_variable(cmv),
        .heat_cool_mode(hc), .remote_setpoint_present(rsp_on), .heater_detect_present(hd), .alarm_out(alarm)
    );
    task automatic print_verdict;
        if (errors == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // a hung handshake ends the run here instead of stalling forever
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            print_verdict;
        end
    end
    // response monitor: the oldest note is compared whenever a response is taken
    always @(posedge aclk) begin
        logic [33:0] e;
        if (rvalid && rready) begin
            e = q_r.pop_front();
            `CHK("rdata", e[31:0], rdata)
            `CHK("rresp", e[33:32], rresp)
        end
        if (bvalid && bready) `CHK("bresp", q_b.pop_front(), bresp)
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
        @(posedge aclk);
        awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        q_b.push_back(r);
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        q_r.push_back({r, d});
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
    endtask
    // let input changes reach alarm_out before the status read
    task automatic st(input logic [3:0] e);
        repeat (3) @(posedge aclk);
        rd(OFF_STATUS, {28'h0, e});
    endtask
    initial begin
        aresetn <= 1'b0; awvalid <= 1'b0; wvalid <= 1'b0; bready <= 1'b0; arvalid <= 1'b0; rready <= 1'b0;
        awaddr <= 8'h0; araddr <= 8'h0; wdata <= 32'h0; wstrb <= 4'h0; hc <= 1'b0; rsp_on <= 1'b0; hd <= 1'b1;
        pv <= 16'sh0; sp <= 16'sh0; rsp <= 16'sh0; mv <= 16'sh0; cmv <= 16'sh0;
        void'($urandom(65199));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        // reset values and an unmapped place
        for (int n = 0; n < 4; n++) rd(OFF_TYPE + 8'(4 * n), 32'h2);
        rd(OFF_HYST + 8'h4, 32'h00320002);
        rd(OFF_ASSIGN, 32'he);
        rd(8'h80, 32'h0, RESP_SLVERR);
        wr(8'h84, 32'h1, RESP_SLVERR);
        wr(OFF_ASSIGN, 32'hf);
        rd(OFF_ASSIGN, 32'hf);
        // manipulated variable upper limit with its 50-count hysteresis
        wr(OFF_TYPE, 32'h10);
        wr(OFF_VALUE, 32'h64);
        @(posedge aclk) mv <= 16'(101 + $urandom_range(0, 1000));
        st(4'b0001);
        @(posedge aclk) mv <= 16'sh3c;
        st(4'b0001);
        @(posedge aclk) mv <= 16'sh32;
        st(4'b0000);
        // heat/cool: lower limit watches only the cooling output
        @(posedge aclk) hc <= 1'b1;
        cmv <= 16'sh1e;
        mv <= 16'sh0;
        wr(OFF_TYPE + 8'h4, 32'h11);
        wr(OFF_VALUE + 8'h4, 32'h14);
        st(4'b0000);
        @(posedge aclk) cmv <= 16'sha;
        st(4'b0010);
        // remote setpoint types need the remote input; codes above 19 are refused
        wr(OFF_TYPE + 8'h8, 32'h12);
        rd(OFF_TYPE + 8'h8, 32'h2);
        @(posedge aclk) rsp_on <= 1'b1;
        rsp <= 16'sh12c;
        wr(OFF_TYPE + 8'h8, 32'h12);
        wr(OFF_VALUE + 8'h8, 32'hc8);
        st(4'b0110);
        wr(OFF_TYPE + 8'hc, 32'h14);
        rd(OFF_TYPE + 8'hc, 32'h2);
        wr(OFF_TYPE + 8'hc, 32'h13);
        wr(OFF_VALUE + 8'hc, 32'h64);
        @(posedge aclk) rsp <= 16'sh32;
        st(4'b1010);
        // hysteresis locked for type 0
        wr(OFF_TYPE, 32'h0);
        wr(OFF_HYST, 32'h00640005);
        rd(OFF_HYST, 32'h00320002);
        // separate limits, and type 5 forced off when the bands overlap
        @(posedge aclk) cmv <= 16'sh1e;
        pv <= 16'sh14;
        wr(OFF_TYPE + 8'h4, 32'h5);
        wr(OFF_LIMIT + 8'h4, 32'h000a000a);
        st(4'b1010);
        wr(OFF_HYST + 8'h4, 32'h0032000a);
        st(4'b1000);
        @(posedge aclk) pv <= -16'sh0f;
        wr(OFF_TYPE + 8'h4, 32'h1);
        st(4'b1010);
        // second reset without heater detection: channel 1 is assigned from the start
        @(posedge aclk) aresetn <= 1'b0;
        hd <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFF_ASSIGN, 32'hf);
        rd(OFF_TYPE + 8'h4, 32'h2);
        st(4'b0000);
        // hysteresis locked for type 12
        wr(OFF_TYPE, 32'hc);
        wr(OFF_HYST, 32'h00640005);
        rd(OFF_HYST, 32'h00320002);
        // type 4 alarms only inside its band
        wr(OFF_TYPE + 8'h4, 32'h4);
        wr(OFF_LIMIT + 8'h4, 32'h000a000a);
        st(4'b0000);
        @(posedge aclk) pv <= 16'sh0;
        st(4'b0010);
        // without heat/cool the lower limit watches the manipulated variable
        @(posedge aclk) hc <= 1'b0;
        mv <= 16'sh5;
        wr(OFF_TYPE + 8'hc, 32'h11);
        wr(OFF_VALUE + 8'hc, 32'h14);
        st(4'b1010);
        repeat (4) @(posedge aclk);
        `CHK("pending", 0, q_r.size() + q_b.size())
        print_verdict;
    end
endmodule
